// *** rtl/scce_core.sv ***
`timescale 1ns/1ns
module scce_core
    import scce_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_reset,
    input  wire logic [INSN_W-1:0]   i_insn,
    input  wire logic                i_irq,
    input  wire logic [DATA_W-1:0]   i_file_rdata,
    input  wire logic [DATA_W-1:0]   i_pc_high_latch,
    output logic      [PC_W-1:0]     o_pc,
    output logic      [FADDR_W-1:0]  o_file_addr,
    output logic                     o_file_we,
    output logic      [DATA_W-1:0]   o_file_wdata,
    output logic      [DATA_W-1:0]   o_work,
    output logic                     o_zero,
    output logic      [PC_W-1:0]     o_stack_top,
    output logic                     o_busy
);

    // ==========================================================================
    // Return stack.
    // ==========================================================================
    scce_stack_if stk ();

    scce_stack scce_stack_inst (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .stk     (stk.store)
    );

    // ==========================================================================
    // Decode.
    // ==========================================================================
    logic                is_skip;
    logic                is_call;
    logic                is_clear_file_register;
    logic                is_clear_working_register;
    logic [BIT_W-1:0]    bit_sel;
    logic                bit_val;

    assign is_skip  = (i_insn[INSN_W-1:SKIP_OP_LSB] == OP_SKIP_SET);
    assign is_call  = (i_insn[INSN_W-1:CALL_OP_LSB] == OP_CALL);
    assign is_clear_file_register  = (i_insn[INSN_W-1:CLEAR_FILE_REGISTER_OP_LSB] == OP_CLR_FILE);
    assign is_clear_working_register  = (i_insn == OP_CLR_WORK);
    assign bit_sel  = i_insn[BIT_LSB+BIT_W-1:BIT_LSB];
    assign bit_val  = i_file_rdata[bit_sel];

    // ==========================================================================
    // File register port.
    // ==========================================================================
    assign o_file_addr = i_insn[FADDR_W-1:0];

    // ==========================================================================
    // Sequencer and architectural state.
    // ==========================================================================
    scce_state_e       state_r;
    scce_state_e       state_nxt;
    logic [PC_W-1:0]   pc_r;
    logic [PC_W-1:0]   pc_nxt;
    logic [PC_W-1:0]   pc_step;
    logic [PC_W-1:0]   pc_skip;
    logic [DATA_W-1:0] work_r;
    logic [DATA_W-1:0] work_nxt;
    logic              zero_r;
    logic              zero_nxt;
    logic              exec_slot;
    logic              take_irq;
    logic              take_call;
    logic              take_skip;
    logic              take_clear_file_register;
    logic              take_clear_working_register;

    // ==========================================================================
    // Issue: an interrupt wins over the fetched word; nothing issues while busy.
    // ==========================================================================
    always_comb begin
        exec_slot = (state_r == SCCE_ST_EXEC);
        take_irq  = exec_slot && i_irq;
        take_call = exec_slot && !i_irq && is_call;
        take_skip = exec_slot && !i_irq && is_skip && bit_val;
        take_clear_file_register = exec_slot && !i_irq && is_clear_file_register;
        take_clear_working_register = exec_slot && !i_irq && is_clear_working_register;
        pc_step   = pc_r + PC_ONE;
        pc_skip   = pc_step + PC_ONE;
    end

    // ==========================================================================
    // Sequencer state: one busy slot after a taken skip, a call or an entry.
    // ==========================================================================
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SCCE_ST_EXEC: begin
                if (take_irq) begin
                    state_nxt = SCCE_ST_IRQ;
                end else if (take_call) begin
                    state_nxt = SCCE_ST_FLUSH;
                end else if (take_skip) begin
                    state_nxt = SCCE_ST_FLUSH;
                end
            end
            SCCE_ST_FLUSH: begin
                state_nxt = SCCE_ST_EXEC;
            end
            SCCE_ST_IRQ: begin
                state_nxt = SCCE_ST_EXEC;
            end
            default: begin
                state_nxt = SCCE_ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= SCCE_ST_EXEC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================================
    // Return stack push: an entry saves the counter itself, a call saves the counter plus one.
    // ==========================================================================
    always_comb begin
        stk.push    = 1'b0;
        stk.push_pc = pc_step;
        if (take_irq) begin
            stk.push    = 1'b1;
            stk.push_pc = pc_r;
        end else if (take_call) begin
            stk.push    = 1'b1;
            stk.push_pc = pc_step;
        end
    end

    // ==========================================================================
    // Program counter: it holds through a busy slot; a taken skip steps by two in one cycle.
    // ==========================================================================
    always_comb begin
        pc_nxt = pc_r;
        if (take_irq) begin
            pc_nxt = IRQ_VECTOR;
        end else if (take_call) begin
            pc_nxt = {i_pc_high_latch[PCH_LATCH_HI:PCH_LATCH_LO],
                      i_insn[KADDR_W-1:0]};
        end else if (take_skip) begin
            pc_nxt = pc_skip;
        end else if (exec_slot) begin
            pc_nxt = pc_step;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pc_r <= PC_RESET;
        end else begin
            pc_r <= pc_nxt;
        end
    end

    // ==========================================================================
    // Working register: only the clear instruction writes it here.
    // ==========================================================================
    always_comb begin
        work_nxt = work_r;
        if (take_clear_working_register) begin
            work_nxt = DATA_ZERO;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            work_r <= DATA_ZERO;
        end else begin
            work_r <= work_nxt;
        end
    end

    // ==========================================================================
    // Zero flag: both clears set it; skips, calls and entries leave it alone.
    // ==========================================================================
    always_comb begin
        zero_nxt = zero_r;
        if (take_clear_file_register) begin
            zero_nxt = 1'b1;
        end
        if (take_clear_working_register) begin
            zero_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            zero_r <= 1'b0;
        end else begin
            zero_r <= zero_nxt;
        end
    end

    // ==========================================================================
    // Outputs.
    // ==========================================================================
    assign o_file_we    = take_clear_file_register;
    assign o_file_wdata = DATA_ZERO;
    assign o_pc         = pc_r;
    assign o_work       = work_r;
    assign o_zero       = zero_r;
    assign o_stack_top  = stk.top_pc;
    assign o_busy       = (state_r != SCCE_ST_EXEC);

endmodule // scce_core

// *** inc/scce_pkg.sv ***
package scce_pkg;

    // ==========================================================================
    // Instruction word and encodings.
    // ==========================================================================
    localparam int          INSN_W        = 14;
    localparam int          PC_W          = 13;
    localparam int          DATA_W        = 8;
    localparam int          FADDR_W       = 7;
    localparam int          BIT_W         = 3;
    localparam int          KADDR_W       = 11;
    localparam int          STACK_DEPTH   = 8;
    localparam int          SP_W          = 3;

    localparam logic [3:0]  OP_SKIP_SET   = 4'h7;
    localparam logic [2:0]  OP_CALL       = 3'h4;
    localparam logic [6:0]  OP_CLR_FILE   = 7'h03;
    localparam logic [13:0] OP_CLR_WORK   = 14'h0103;
    localparam logic [13:0] INSN_NOP      = 14'h0000;

    // ==========================================================================
    // Field positions.
    // ==========================================================================
    localparam int          SKIP_OP_LSB   = 10;
    localparam int          CALL_OP_LSB   = 11;
    localparam int          CLEAR_FILE_REGISTER_OP_LSB   = 7;
    localparam int          BIT_LSB       = 7;
    localparam int          PCH_LATCH_HI  = 4;
    localparam int          PCH_LATCH_LO  = 3;

    localparam logic [PC_W-1:0]   PC_RESET    = 13'h0000;
    localparam logic [PC_W-1:0]   PC_ONE      = 13'h0001;
    localparam logic [PC_W-1:0]   IRQ_VECTOR  = 13'h0004;
    localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
    localparam logic [SP_W-1:0]   SP_ONE      = 3'h1;

    typedef enum logic [2:0] {
        SCCE_ST_EXEC  = 3'b001,
        SCCE_ST_FLUSH = 3'b010,
        SCCE_ST_IRQ   = 3'b100
    } scce_state_e;

endpackage

// *** inc/scce_stack_if.sv ***
`timescale 1ns/1ns
interface scce_stack_if;
    import scce_pkg::*;
    logic            push;
    logic [PC_W-1:0] push_pc;
    logic [PC_W-1:0] top_pc;

    modport ctrl (output push, output push_pc, input top_pc);
    modport store (input push, input push_pc, output top_pc);
endinterface

// *** rtl/scce_stack.sv ***
`timescale 1ns/1ns
module scce_stack
    import scce_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_reset,
    scce_stack_if.store stk
);

    // ==========================================================================
    // Circular return stack held in flip-flops.
    // ==========================================================================
    logic [PC_W-1:0] mem_r [STACK_DEPTH];
    logic [PC_W-1:0] mem_nxt [STACK_DEPTH];
    logic [SP_W-1:0] sp_r;
    logic [SP_W-1:0] sp_nxt;

    always_comb begin
        mem_nxt = mem_r;
        sp_nxt  = sp_r;
        if (stk.push) begin
            mem_nxt[sp_r] = stk.push_pc;
            sp_nxt        = sp_r + SP_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sp_r <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                mem_r[i] <= PC_RESET;
            end
        end else begin
            sp_r  <= sp_nxt;
            mem_r <= mem_nxt;
        end
    end

    assign stk.top_pc = mem_r[sp_r - SP_ONE];

endmodule // scce_stack

// *** tb/scce_file_model.sv ***
`timescale 1ns/1ns
// ====
// Data register file, combinational read.
module scce_file_model
    import scce_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic [FADDR_W-1:0] i_addr,
    input  wire logic               i_we,
    input  wire logic [DATA_W-1:0]  i_wdata,
    output logic      [DATA_W-1:0]  o_rdata
);
    logic [DATA_W-1:0] mem [128];
    assign o_rdata = mem[i_addr];
    always @(posedge i_clk) begin
        if (i_we) mem[i_addr] <= i_wdata;
    end
endmodule // scce_file_model

// *** tb/scce_core_sva.sv ***
`timescale 1ns/1ns
// ====
// Port checker.
module scce_core_sva
    import scce_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_reset,
    input wire logic [INSN_W-1:0] i_insn,
    input wire logic              i_irq,
    input wire logic [DATA_W-1:0] i_file_rdata,
    input wire logic [DATA_W-1:0] i_pc_high_latch,
    input wire logic [PC_W-1:0]   o_pc,
    input wire logic [6:0]        o_file_addr,
    input wire logic              o_file_we,
    input wire logic [DATA_W-1:0] o_file_wdata,
    input wire logic [DATA_W-1:0] o_work,
    input wire logic              o_zero,
    input wire logic [PC_W-1:0]   o_stack_top,
    input wire logic              o_busy
);
    wire ex  = !o_busy && !i_irq;
    wire skp = ex && i_insn[13:10] == OP_SKIP_SET;
    wire hit = i_file_rdata[i_insn[9:7]];
    wire cal = ex && i_insn[13:11] == OP_CALL;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_skip_taken: assert property (skp && hit |=> o_busy ##1 !o_busy && o_pc == $past(o_pc, 2) + 13'h0002)
        else $error("taken skip wrong");
    a_skip_plain: assert property (skp && !hit |=> !o_busy && $stable(o_zero) && o_pc == $past(o_pc) + PC_ONE)
        else $error("plain skip wrong");
    a_call_push: assert property (cal |=> o_busy && o_stack_top == $past(o_pc) + PC_ONE)
        else $error("call push wrong");
    a_call_low: assert property (cal |=> o_pc[10:0] == $past(i_insn[10:0]))
        else $error("call target wrong");
    a_call_high: assert property (cal |=> o_pc[12:11] == $past(i_pc_high_latch[4:3]))
        else $error("call high bits wrong");
    a_call_lands: assert property (cal |-> ##2 o_pc == {$past(i_pc_high_latch[4:3], 2), $past(i_insn[10:0], 2)})
        else $error("call landing wrong");
    a_call_cycles: assert property (cal |=> $stable(o_zero) ##1 !o_busy)
        else $error("call length wrong");
    a_clear_file: assert property (ex && i_insn[13:7] == OP_CLR_FILE |-> o_file_we && o_file_wdata == DATA_ZERO
        && o_file_addr == i_insn[6:0] ##1 o_zero) else $error("clear file wrong");
    a_clear_work: assert property (ex && i_insn == OP_CLR_WORK |=> o_work == DATA_ZERO && o_zero)
        else $error("clear work wrong");
    a_irq_entry: assert property (!o_busy && i_irq |=> o_stack_top == $past(o_pc) && o_pc == IRQ_VECTOR
        && $stable(o_work) && $stable(o_zero)) else $error("irq entry wrong");
endmodule // scce_core_sva
bind scce_core scce_core_sva scce_core_sva_inst (
    .i_clk           (i_clk),
    .i_reset         (i_reset),
    .i_insn          (i_insn),
    .i_irq           (i_irq),
    .i_file_rdata    (i_file_rdata),
    .i_pc_high_latch (i_pc_high_latch),
    .o_pc            (o_pc),
    .o_file_addr     (o_file_addr),
    .o_file_we       (o_file_we),
    .o_file_wdata    (o_file_wdata),
    .o_work          (o_work),
    .o_zero          (o_zero),
    .o_stack_top     (o_stack_top),
    .o_busy          (o_busy)
);

// *** tb/skip_call_clear_execute_tb_top.sv ***
`timescale 1ns/1ns
// ====
// Testbench.
module skip_call_clear_execute_tb_top;
    import scce_pkg::*;
    logic               i_clk = 1'b0;
    logic               i_reset = 1'b1;
    logic               i_irq = 1'b0;
    logic [INSN_W-1:0]  i_insn = INSN_NOP;
    logic [DATA_W-1:0]  i_pc_high_latch = 8'h00;
    logic [DATA_W-1:0]  rdata, wdata, work;
    logic [FADDR_W-1:0] faddr;
    logic [PC_W-1:0]    pc, top, p;
    logic               we, zero, busy;
    int                 n_fail = 0, samples_checked = 0, cycles = 0;
    scce_core scce_core_inst (.i_clk(i_clk), .i_reset(i_reset), .i_insn(i_insn), .i_irq(i_irq),
        .i_file_rdata(rdata), .i_pc_high_latch(i_pc_high_latch), .o_pc(pc), .o_file_addr(faddr),
        .o_file_we(we), .o_file_wdata(wdata), .o_work(work), .o_zero(zero), .o_stack_top(top), .o_busy(busy));
    scce_file_model scce_file_model_inst (.i_clk(i_clk), .i_addr(faddr), .i_we(we), .i_wdata(wdata), .o_rdata(rdata));
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic put(input logic [INSN_W-1:0] w);
        @(posedge i_clk) i_insn <= w;
    endtask
    task automatic test_clear_work();
        put(OP_CLR_WORK);
        #1 p = pc;
        put(INSN_NOP);
        #1 chk("work", 32'(work), 32'h0);
        chk("zero", 32'(zero), 32'h1);
        chk("pc", 32'(pc), 32'(p) + 1);
        $display("clear work done");
    endtask
    task automatic test_skip();
        scce_file_model_inst.mem[5] = 8'h80;
        for (int b = 7; b >= 0; b -= 7) begin
            put({OP_SKIP_SET, 3'(b), 7'h05});
            #1 p = pc;
            put(INSN_NOP);
            #1 chk("skip busy", 32'(busy), 32'(b == 7));
            if (b == 7) begin
                put(INSN_NOP);
                #1;
            end
            chk("skip pc", 32'(pc), 32'(p) + 32'(b == 7) + 1);
            chk("skip zero", 32'(zero), 32'h1);
        end
        $display("skip done");
    endtask
    task automatic test_call();
        @(posedge i_clk) i_pc_high_latch <= 8'hF7;
        put({OP_CALL, 11'h7FE});
        #1 p = pc;
        put({OP_CLR_FILE, 7'h7F});
        #1 chk("call push", 32'(top), 32'(p) + 1);
        chk("call high", 32'(pc[12:11]), 32'h2);
        chk("call busy", 32'(busy), 32'h1);
        chk("call refused", 32'(we), 32'h0);
        put(INSN_NOP);
        #1 chk("call pc", 32'(pc), 32'h17FE);
        chk("call done", 32'(busy), 32'h0);
        chk("call zero", 32'(zero), 32'h1);
        $display("call done");
    endtask
    task automatic test_clear_file();
        @(posedge i_clk) i_reset <= 1'b1;
        @(posedge i_clk) i_reset <= 1'b0;
        #1 chk("reset zero", 32'(zero), 32'h0);
        chk("reset pc", 32'(pc), 32'(PC_RESET));
        scce_file_model_inst.mem[127] = 8'h5A;
        put({OP_CLR_FILE, 7'h7F});
        #1 p = pc;
        chk("file we", 32'(we), 32'h1);
        put(INSN_NOP);
        #1 chk("file", 32'(scce_file_model_inst.mem[127]), 32'h0);
        chk("file zero", 32'(zero), 32'h1);
        chk("pc", 32'(pc), 32'(p) + 1);
        $display("clear file done");
    endtask
    task automatic test_irq();
        scce_file_model_inst.mem[127] = 8'h5A;
        @(posedge i_clk) i_irq <= 1'b1;
        #1 p = pc;
        @(posedge i_clk) begin
            i_irq  <= 1'b0;
            i_insn <= {OP_CLR_FILE, 7'h7F};
        end
        #1 chk("irq push", 32'(top), 32'(p));
        chk("irq pc", 32'(pc), 32'(IRQ_VECTOR));
        chk("irq work", 32'(work), 32'h0);
        chk("irq zero", 32'(zero), 32'h1);
        chk("irq refused", 32'(we), 32'h0);
        put(INSN_NOP);
        #1 chk("irq hold", 32'(pc), 32'(IRQ_VECTOR));
        chk("irq file", 32'(scce_file_model_inst.mem[127]), 32'h5A);
        $display("irq done");
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        test_clear_work();
        test_skip();
        test_call();
        test_clear_file();
        test_irq();
        conclude();
    end
endmodule // skip_call_clear_execute_tb_top
